// [amtr_bank.v]
// Alarm suppress, event status and trim register bank behind the serial control port.
// Assumes serial clock at most one eighth of CLK; events and fuse values come from CLK logic.
`timescale 1ns/10ps
`default_nettype none
`include "amtr_regs.vh"
module amtr_bank #(
  parameter TIME_N = 6,
  parameter OFF_N = 2,
  parameter TW = 8,
  parameter OW = 12
) (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Serial control port
  input wire SCS_N,
  input wire SCLK,
  input wire SDI,
  output wire SDO,
  output wire SDO_OE,
  // Alarm events and summary
  input wire REALIGN_EVENT,
  input wire DIVIDER_MISMATCH_EVENT,
  output wire ALERT_SUMMARY,
  // Fuse defaults and trim outputs
  input wire [TIME_N*TW-1:0] FUSE_TIME_TRIM,
  input wire [OFF_N*OW-1:0] FUSE_OFFSET_TRIM,
  output wire [TIME_N*TW-1:0] TIME_TRIM,
  output wire [OFF_N*OW-1:0] OFFSET_TRIM
);
  // ----------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------------------------------
  wire [2:0] pins_s;
  reg sclk_prev_q;
  amtr_sync #(.W(3), .INIT(3'h4)) u_sync (
    .CLK(CLK),
    .RST(RST),
    .D({SCS_N, SCLK, SDI}),
    .Q(pins_s)
  );
  wire cs_n_s = pins_s[2];
  wire sclk_s = pins_s[1];
  wire sdi_s = pins_s[0];
  wire rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
  wire fall = ~sclk_s & sclk_prev_q & ~cs_n_s;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  reg [TW-1:0] time_q [0:TIME_N-1];
  reg [OW-1:0] off_q [0:OFF_N-1];
  reg realign_sup_q;
  reg divider_sup_q;
  reg realign_flag_q;
  reg divider_flag_q;
  reg summary_q;

  // Serial engine state.
  reg [4:0] cnt_q;
  reg [14:0] hdr_q;
  reg [14:0] addr_q;
  reg rd_q;
  reg [6:0] din_q;
  reg [7:0] dout_q;
  reg sdo_q;
  reg sdo_oe_q;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Per core mode slots
  function [2:0] time_idx;
    input [14:0] a;
    begin
      if (a == `AMTR_ADDR_TIME_A_DUAL) time_idx = 3'h0;
      else if (a == `AMTR_ADDR_TIME_B_DUAL) time_idx = 3'h1;
      else if (a == `AMTR_ADDR_TIME_AQ_IN1) time_idx = 3'h2;
      else if (a == `AMTR_ADDR_TIME_BI_IN1) time_idx = 3'h3;
      else if (a == `AMTR_ADDR_TIME_AQ_IN2) time_idx = 3'h4;
      else if (a == `AMTR_ADDR_TIME_BI_IN2) time_idx = 3'h5;
      else time_idx = `AMTR_TIME_NONE;
    end
  endfunction

  // Returns {hit, index, high byte}.
  function [2:0] off_sel;
    input [14:0] a;
    begin
      if (a == `AMTR_ADDR_OFF_IN1_LO) off_sel = 3'h4;
      else if (a == `AMTR_ADDR_OFF_IN1_HI) off_sel = 3'h5;
      else if (a == `AMTR_ADDR_OFF_IN2_LO) off_sel = 3'h6;
      else if (a == `AMTR_ADDR_OFF_IN2_HI) off_sel = 3'h7;
      else off_sel = 3'h0;
    end
  endfunction

  // Unmapped addresses and reserved bits read as zero.
  function [7:0] read_byte;
    input [14:0] a;
    reg [2:0] ti;
    reg [2:0] os;
    begin
      ti = time_idx(a);
      os = off_sel(a);
      read_byte = 8'h00;
      if (a == `AMTR_ADDR_SUMMARY) begin
        read_byte[0] = summary_q;
      end else if (a == `AMTR_ADDR_STATUS) begin
        read_byte[`AMTR_REALIGN_BIT] = realign_flag_q;
        read_byte[`AMTR_DIVIDER_BIT] = divider_flag_q;
      end else if (a == `AMTR_ADDR_SUPPRESS) begin
        read_byte[`AMTR_REALIGN_BIT] = realign_sup_q;
        read_byte[`AMTR_DIVIDER_BIT] = divider_sup_q;
      end else if (ti != `AMTR_TIME_NONE) begin
        read_byte = time_q[ti];
      end else if (os[2] && os[0]) begin
        read_byte = {4'h0, off_q[os[1]][OW-1:8]};
      end else if (os[2]) begin
        read_byte = off_q[os[1]][7:0];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Serial frame engine
  // ----------------------------------------------------------------
  wire data_done = rise && (cnt_q == `AMTR_CNT_DATA_LAST);
  wire wr_stb = data_done && !rd_q;
  wire [7:0] wr_data = {din_q, sdi_s};
  wire [14:0] addr_next = addr_q + 15'h0001;
  wire [2:0] wr_ti = time_idx(addr_q);
  wire [2:0] wr_os = off_sel(addr_q);

  always @(posedge CLK) begin
    if (RST) begin
      sclk_prev_q <= 1'b0;
      cnt_q <= 5'h00;
      hdr_q <= 15'h0000;
      addr_q <= 15'h0000;
      rd_q <= 1'b0;
      din_q <= 7'h00;
      dout_q <= 8'h00;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      if (cs_n_s) begin
        cnt_q <= 5'h00;
        sdo_oe_q <= 1'b0;
      end else if (rise) begin
        if (cnt_q < `AMTR_CNT_DATA_FIRST) begin
          hdr_q <= {hdr_q[13:0], sdi_s};
          cnt_q <= cnt_q + 5'h01;
          // After fifteen shifts the read flag sits at the top; the fourteen bits below it and the current SDI bit make the address.
          if (cnt_q == `AMTR_CNT_ADDR_LAST) begin
            rd_q <= hdr_q[14];
            addr_q <= {hdr_q[13:0], sdi_s};
            dout_q <= read_byte({hdr_q[13:0], sdi_s});
          end
        end else if (data_done) begin
          // Streaming: the next byte goes to the next address.
          cnt_q <= `AMTR_CNT_DATA_FIRST;
          addr_q <= addr_next;
          dout_q <= read_byte(addr_next);
        end else begin
          din_q <= {din_q[5:0], sdi_s};
          cnt_q <= cnt_q + 5'h01;
        end
      end else if (fall && rd_q && (cnt_q >= `AMTR_CNT_DATA_FIRST)) begin
        sdo_q <= dout_q[7];
        dout_q <= {dout_q[6:0], 1'b0};
        sdo_oe_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Trim registers
  // ----------------------------------------------------------------
  integer i;
  always @(posedge CLK) begin
    if (RST) begin
      for (i = 0; i < TIME_N; i = i + 1) begin
        time_q[i] <= FUSE_TIME_TRIM[i*TW +: TW];
      end
      for (i = 0; i < OFF_N; i = i + 1) begin
        off_q[i] <= FUSE_OFFSET_TRIM[i*OW +: OW];
      end
    end else if (wr_stb) begin
      if (wr_ti != `AMTR_TIME_NONE) begin
        time_q[wr_ti] <= wr_data;
      end
      if (wr_os[2] && wr_os[0]) begin
        off_q[wr_os[1]][OW-1:8] <= wr_data[OW-9:0];
      end else if (wr_os[2]) begin
        off_q[wr_os[1]][7:0] <= wr_data;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < TIME_N; g = g + 1) begin : g_time
      assign TIME_TRIM[g*TW +: TW] = time_q[g];
    end
    for (g = 0; g < OFF_N; g = g + 1) begin : g_off
      assign OFFSET_TRIM[g*OW +: OW] = off_q[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Suppress mask, event flags and summary
  // ----------------------------------------------------------------
  wire wr_status = wr_stb && (addr_q == `AMTR_ADDR_STATUS);
  wire wr_suppress = wr_stb && (addr_q == `AMTR_ADDR_SUPPRESS);
  wire [7:0] sup_rst = `AMTR_SUPPRESS_RESET;
  wire [7:0] flag_rst = `AMTR_STATUS_RESET;

  always @(posedge CLK) begin
    if (RST) begin
      realign_sup_q <= sup_rst[`AMTR_REALIGN_BIT];
      divider_sup_q <= sup_rst[`AMTR_DIVIDER_BIT];
      realign_flag_q <= flag_rst[`AMTR_REALIGN_BIT];
      divider_flag_q <= flag_rst[`AMTR_DIVIDER_BIT];
      summary_q <= 1'b0;
    end else begin
      if (wr_suppress) begin
        realign_sup_q <= wr_data[`AMTR_REALIGN_BIT];
        divider_sup_q <= wr_data[`AMTR_DIVIDER_BIT];
      end
      realign_flag_q <= REALIGN_EVENT |
        (realign_flag_q & ~(wr_status & wr_data[`AMTR_REALIGN_BIT]));
      divider_flag_q <= DIVIDER_MISMATCH_EVENT |
        (divider_flag_q & ~(wr_status & wr_data[`AMTR_DIVIDER_BIT]));
      summary_q <= (realign_flag_q & ~realign_sup_q) | (divider_flag_q & ~divider_sup_q);
    end
  end

  assign SDO = sdo_q;
  assign SDO_OE = sdo_oe_q;
  assign ALERT_SUMMARY = summary_q;
endmodule
`default_nettype wire

// [amtr_bank_monitor.sv]
// Assertion checker for the alarm mask and trim register bank.
// Sees only the bank's ports; one clock, synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module amtr_bank_monitor #(
  parameter TIME_N = 6,
  parameter OFF_N = 2,
  parameter TW = 8,
  parameter OW = 12
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Watched ports
  input wire logic SCS_N,
  input wire logic SDO_OE,
  input wire logic REALIGN_EVENT,
  input wire logic DIVIDER_MISMATCH_EVENT,
  input wire logic ALERT_SUMMARY,
  input wire logic [TIME_N*TW-1:0] FUSE_TIME_TRIM,
  input wire logic [OFF_N*OW-1:0] FUSE_OFFSET_TRIM,
  input wire logic [TIME_N*TW-1:0] TIME_TRIM,
  input wire logic [OFF_N*OW-1:0] OFFSET_TRIM
);
  // --------------------------------------------------------------
  // Idle tracking and assertions
  // --------------------------------------------------------------
  // At full count no frame write can still be pending, so trim registers must hold and the summary cannot fall.
  logic [3:0] idle_q;
  always_ff @(posedge CLK) begin
    if (RST || !SCS_N) begin
      idle_q <= 4'h0;
    end else if (idle_q != 4'hF) begin
      idle_q <= idle_q + 4'h1;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  reset_summary_a: assert property ($fell(RST) |-> !ALERT_SUMMARY && !SDO_OE)
    else $error("summary or drive enable set after reset");
  fuse_time_a: assert property ($fell(RST) |-> TIME_TRIM == $past(FUSE_TIME_TRIM))
    else $error("time trims not loaded from fuses");
  fuse_offset_a: assert property ($fell(RST) |-> OFFSET_TRIM == $past(FUSE_OFFSET_TRIM))
    else $error("offset trims not loaded from fuses");
  oe_idle_a: assert property (SCS_N [*6] |-> !SDO_OE)
    else $error("data out driven while deselected");
  trim_hold_a: assert property (idle_q == 4'hF |-> $stable(TIME_TRIM) && $stable(OFFSET_TRIM))
    else $error("trim changed without a write");
  summary_fall_a: assert property (idle_q == 4'hF |-> !$fell(ALERT_SUMMARY))
    else $error("summary cleared without software");
  summary_rise_a: assert property (idle_q == 4'hF && $rose(ALERT_SUMMARY) |->
    $past(REALIGN_EVENT, 2) || $past(DIVIDER_MISMATCH_EVENT, 2))
    else $error("summary rose without an event");
  summary_hold_a: assert property (idle_q == 4'hF && !$past(REALIGN_EVENT, 2) &&
    !$past(DIVIDER_MISMATCH_EVENT, 2) |-> $stable(ALERT_SUMMARY))
    else $error("summary changed without cause");
  cover property ($rose(ALERT_SUMMARY));
  cover property ($fell(ALERT_SUMMARY));
  cover property ($rose(SDO_OE));
  cover property ($fell(RST));
endmodule
bind amtr_bank amtr_bank_monitor #(.TIME_N(TIME_N), .OFF_N(OFF_N), .TW(TW), .OW(OW)) mon_u (
  .CLK(CLK), .RST(RST), .SCS_N(SCS_N), .SDO_OE(SDO_OE), .REALIGN_EVENT(REALIGN_EVENT),
  .DIVIDER_MISMATCH_EVENT(DIVIDER_MISMATCH_EVENT), .ALERT_SUMMARY(ALERT_SUMMARY),
  .FUSE_TIME_TRIM(FUSE_TIME_TRIM), .FUSE_OFFSET_TRIM(FUSE_OFFSET_TRIM),
  .TIME_TRIM(TIME_TRIM), .OFFSET_TRIM(OFFSET_TRIM));
`default_nettype wire

// [amtr_bank_test.sv]
// Self-checking bench for the alarm mask and trim register bank.
// Drives every input 1 ns after a rising edge; serial clock halves last 5 CLK.
`timescale 1ns/10ps
`default_nettype none
module amtr_bank_test;
  logic clk, rst, scs_n, sclk, sdi, sdo, sdo_oe, rev, dev, summ;
  logic [47:0] fuse_t, tt;
  logic [23:0] fuse_o, ot;
  logic [7:0] rd;
  logic oe_rd;
  logic [14:0] taddr [6] = '{15'h0310, 15'h0313, 15'h0314, 15'h0315, 15'h031A, 15'h031B};
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  amtr_bank dut_u (.CLK(clk), .RST(rst), .SCS_N(scs_n), .SCLK(sclk), .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe),
    .REALIGN_EVENT(rev), .DIVIDER_MISMATCH_EVENT(dev), .ALERT_SUMMARY(summ), .FUSE_TIME_TRIM(fuse_t),
    .FUSE_OFFSET_TRIM(fuse_o), .TIME_TRIM(tt), .OFFSET_TRIM(ot));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string name, input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic results;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // --------------------------------------------------------------
  // Serial frame: read flag, 15-bit address, one data byte
  // --------------------------------------------------------------
  // Read bits are taken just before each rise, long after the falling-edge update.
  task automatic xfer(input logic rw, input logic [14:0] a, input logic [7:0] wd);
    logic [23:0] frame;
    frame = {rw, a, wd};
    scs_n = 1'b0;
    for (int k = 23; k >= 0; k--) begin
      sdi = frame[k];
      tick(5);
      if (k < 8) begin
        rd[k] = sdo;
        oe_rd = sdo_oe;
      end
      sclk = 1'b1;
      tick(5);
      sclk = 1'b0;
    end
    tick(5);
    scs_n = 1'b1;
    tick(16);
  endtask
  task automatic rdchk(input string name, input logic [14:0] a, input logic [7:0] exp);
    xfer(1'b1, a, 8'h00);
    chk(name, rd, exp);
    chk("drive enable", oe_rd, 1'b1);
    chk("drive released", sdo_oe, 1'b0);
  endtask
  initial begin
    forever begin
      tick(1);
      cycles++;
      if (cycles == 20000) begin
        bad_count++;
        results();
      end
    end
  end
  initial begin
    rst = 1'b1;
    scs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    rev = 1'b0;
    dev = 1'b0;
    fuse_t = 48'hA5C3_1E7F_0092;
    fuse_o = 24'h9E_147B;
    tick(5);
    rst = 1'b0;
    tick(3);
    chk("summary pin", summ, 1'b0);
    chk("time trims", tt, fuse_t);
    chk("offset trims", ot, fuse_o);
    rdchk("suppress", 15'h02C2, 8'h05);
    rdchk("status", 15'h02C1, 8'h05);
    rdchk("unmapped", 15'h0300, 8'h00);
    for (int i = 0; i < 6; i++) begin
      rdchk("trim default", taddr[i], fuse_t[8*i +: 8]);
      xfer(1'b0, taddr[i], 8'h30 + 8'(i));
      rdchk("trim readback", taddr[i], 8'h30 + 8'(i));
    end
    chk("trim outputs", tt, 48'h3534_3332_3130);
    xfer(1'b0, 15'h0344, 8'hAB);
    xfer(1'b0, 15'h0345, 8'hFC);
    xfer(1'b0, 15'h0346, 8'h12);
    xfer(1'b0, 15'h0347, 8'h3F);
    chk("offset outputs", ot, 24'hF1_2CAB);
    rdchk("offset high", 15'h0345, 8'h0C);
    xfer(1'b0, 15'h02C2, 8'hFF);
    rdchk("suppress", 15'h02C2, 8'h05);
    chk("summary pin", summ, 1'b0);
    xfer(1'b0, 15'h02C2, 8'h04);
    chk("summary pin", summ, 1'b1);
    xfer(1'b0, 15'h02C1, 8'h01);
    chk("summary pin", summ, 1'b0);
    rdchk("status", 15'h02C1, 8'h04);
    dev = 1'b1;
    tick(1);
    dev = 1'b0;
    chk("summary pin", summ, 1'b0);
    tick(1);
    chk("summary pin", summ, 1'b1);
    xfer(1'b0, 15'h02C1, 8'h05);
    chk("summary pin", summ, 1'b0);
    rdchk("summary", 15'h02C0, 8'h00);
    xfer(1'b0, 15'h02C2, 8'h05);
    rev = 1'b1;
    dev = 1'b1;
    tick(1);
    rev = 1'b0;
    dev = 1'b0;
    tick(4);
    chk("summary pin", summ, 1'b0);
    rdchk("status", 15'h02C1, 8'h05);
    xfer(1'b0, 15'h02C2, 8'h01);
    chk("summary pin", summ, 1'b1);
    rdchk("summary", 15'h02C0, 8'h01);
    fuse_t = 48'h0F1E_2D3C_4B5A;
    fuse_o = 24'h76_5432;
    rst = 1'b1;
    tick(5);
    rst = 1'b0;
    tick(3);
    chk("time trims", tt, fuse_t);
    chk("offset trims", ot, fuse_o);
    chk("summary pin", summ, 1'b0);
    results();
  end
endmodule
`default_nettype wire

// [amtr_regs.vh]
// Constants for the alarm mask and trim register bank.
// Assumes a single 200 MHz clock and a slow serial control port sampled on it.
`ifndef AMTR_REGS_VH
`define AMTR_REGS_VH

// ----------------------------------------------------------------
// Register addresses (15-bit byte addresses)
// ----------------------------------------------------------------
`define AMTR_ADDR_SUMMARY 15'h02C0
`define AMTR_ADDR_STATUS 15'h02C1
`define AMTR_ADDR_SUPPRESS 15'h02C2
`define AMTR_ADDR_TIME_A_DUAL 15'h0310
`define AMTR_ADDR_TIME_B_DUAL 15'h0313
`define AMTR_ADDR_TIME_AQ_IN1 15'h0314
`define AMTR_ADDR_TIME_BI_IN1 15'h0315
`define AMTR_ADDR_TIME_AQ_IN2 15'h031A
`define AMTR_ADDR_TIME_BI_IN2 15'h031B
`define AMTR_ADDR_OFF_IN1_LO 15'h0344
`define AMTR_ADDR_OFF_IN1_HI 15'h0345
`define AMTR_ADDR_OFF_IN2_LO 15'h0346
`define AMTR_ADDR_OFF_IN2_HI 15'h0347

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define AMTR_REALIGN_BIT 2
`define AMTR_DIVIDER_BIT 0
`define AMTR_SUPPRESS_RESET 8'h05
`define AMTR_STATUS_RESET 8'h05

// ----------------------------------------------------------------
// Serial frame layout: R/W bit, 15 address bits, data bytes
// ----------------------------------------------------------------
`define AMTR_CNT_ADDR_LAST 5'h0F
`define AMTR_CNT_DATA_FIRST 5'h10
`define AMTR_CNT_DATA_LAST 5'h17
`define AMTR_TIME_NONE 3'h7

`endif

// [amtr_sync.v]
// Two-flop synchroniser for asynchronous pin inputs.
// Assumes inputs change slowly compared with CLK.
`timescale 1ns/10ps
`default_nettype none
module amtr_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Data
  input wire [W-1:0] D,
  output wire [W-1:0] Q
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge CLK) begin
    if (RST) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= D;
      sync_q <= meta_q;
    end
  end

  assign Q = sync_q;
endmodule
`default_nettype wire
